// ---- aspv_antenna_model.sv ----
/*
 * Behavioural model of the external bias switch and sense circuit.
 * Assumes both sense lines carry pull-ups and that the bench sets the
 * fault and connection state of the antenna.
 */
`timescale 1ns/1ns
module aspv_antenna_model (
	// Antenna state set by the bench
	input  wire logic i_short_fault,
	input  wire logic i_connected,
	// Pins of the supervisor
	input  wire logic i_antenna_supply_off_out,
	output logic      o_antenna_short_in_low,
	output logic      o_antenna_present_in
);
	logic powered;

	assign powered = !i_antenna_supply_off_out;
	// Without bias the short cannot pull the line; the pull-up wins
	assign o_antenna_short_in_low = !(i_short_fault && powered);
	// Current flows only into a powered, connected or shorted load
	assign o_antenna_present_in = powered && (i_connected || i_short_fault);
endmodule

// ---- aspv_pkg.sv ----
/*
 * Constants, types and register map of the antenna supervisor.
 * Assumes one 125 MHz clock and an AXI4-Lite master with 32-bit data.
 */
// Operation
// [R1] No antenna status is reported while supply control is off.
// [R2] A 1 in the supply-control setting switches supply control on.
// [R3] The supply-off output is active high: low powers the antenna.
// [R4] With short detection on, a low short input counts as a short.
// [R5] A short without power-down reports SHORT and keeps power on.
// [R6] SHORT stays until recovery timeout, power cycle or detect toggle.
// [R7] A 1 in the short-recovery setting enables timed recovery.
// [R8] With recovery on, a short cuts power and reports power OFF.
// [R9] After the timeout power returns and no short gives OK, power ON.
// [R10] A 1 in the open-detect setting enables open detection.
// [R11] With open detection on, low present input is OPEN, high is OK.
// [R12] The far circuit drives present high while current is drawn.
// [R13] At start the feature list is sent, then INIT, then OK.
// [R14] With an antenna connected the first state after start is OK.
// [R15] Recovery time is a parameter and inputs are synchronised.
package aspv_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFF_CONFIG  = 8'h00;
	localparam logic [7:0]  OFF_STATUS  = 8'h04;
	localparam logic [7:0]  OFF_FEATURE = 8'h08;
	localparam logic [7:0]  OFF_IRQ_ST  = 8'h0c;
	localparam logic [7:0]  OFF_IRQ_CLR = 8'h10;
	localparam logic [7:0]  OFF_IRQ_EN  = 8'h14;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic power_down_on_short;
		logic open_detect_enable;
		logic short_recovery_enable;
		logic short_detect_enable;
		logic supply_control_enable;
	} aspv_cfg_type;

	localparam logic [4:0]  CFG_RST     = 5'h00;
	localparam int          EV_W        = 4;
	localparam int          EV_SHORT    = 0;
	localparam int          EV_OPEN     = 1;
	localparam int          EV_OK       = 2;
	localparam int          EV_RETEST   = 3;

	typedef enum logic [1:0] {
		ANT_INIT  = 2'h0,
		ANT_OK    = 2'h1,
		ANT_SHORT = 2'h2,
		ANT_OPEN  = 2'h3
	} aspv_ant_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FEAT = 4'h2,
		ST_INIT = 4'h4,
		ST_RUN  = 4'h8
	} aspv_fsm_type;

	localparam logic MSG_FEATURES = 1'h0;
	localparam logic MSG_STATUS   = 1'h1;

	typedef struct packed {
		logic       valid;
		logic       kind;
		logic [4:0] code;
	} aspv_msg_type;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ     = 125;
	localparam int RECOVER_MS  = 1000;
	localparam int RECOVER_CYC = RECOVER_MS * CLK_MHZ * 1000;
	localparam int SETTLE_CYC  = 4;

	// ------------------------------------------------------------
	// AXI4-Lite carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} aspv_axi_in_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} aspv_axi_out_type;

endpackage

// ---- aspv_sync.sv ----
/*
 * Two-flop synchroniser for the antenna sense inputs.
 * Assumes inputs idle high, as the pads carry pull-ups.
 */
`timescale 1ns/1ns
module aspv_sync
	import aspv_pkg::*;
#(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	// Lines
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} aspv_sync_state_type;

	aspv_sync_state_type r;
	aspv_sync_state_type next_r;

	always_comb begin
		next_r.meta = i_async;
		next_r.sync = r.meta;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign o_sync = r.sync;

endmodule

// ---- aspv_timer.sv ----
/*
 * One-shot down counter for recovery and re-test delays.
 * Assumes i_count is at least one when i_start pulses.
 */
`timescale 1ns/1ns
module aspv_timer
	import aspv_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Control
	input  wire logic        i_start,
	input  wire logic [31:0] i_count,
	output logic             o_done
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        busy;
		logic        done;
	} aspv_timer_state_type;

	aspv_timer_state_type r;
	aspv_timer_state_type next_r;

	// Restart wins over a running count
	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		if (i_start) begin
			next_r.cnt  = i_count - 32'h1;
			next_r.busy = 1'b1;
		end else if (r.busy) begin
			if (r.cnt == 32'h0) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end else begin
				next_r.cnt = r.cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_done = r.done;

endmodule

// ---- aspv_top.sv ----
/*
 * Active antenna supervisor with AXI4-Lite registers and interrupt.
 * Assumes the short and present pads sit on pull-ups and that the
 * external bias switch follows the supply-off output.
 */
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module aspv_top
	import aspv_pkg::*;
#(
	parameter int P_RECOVER_CYC = RECOVER_CYC
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// Register bus
	input  wire aspv_axi_in_type  i_axi,
	output aspv_axi_out_type      o_axi,
	// Antenna pins
	input  wire logic             i_antenna_short_in_low,
	input  wire logic             i_antenna_present_in,
	output logic                  o_antenna_supply_off_out,
	// Status messages and interrupt
	output aspv_msg_type          o_msg,
	output logic                  o_irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		aspv_fsm_type      fsm;
		aspv_cfg_type      cfg;
		aspv_ant_type      ant;
		logic              supply_off;
		logic              retest;
		logic              tmr_start;
		logic              tmr_long;
		aspv_msg_type      msg;
		logic [EV_W-1:0]   irq_st;
		logic [EV_W-1:0]   irq_en;
		logic              irq;
		logic              aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic              w_held;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		aspv_axi_out_type  axi;
	} aspv_top_state_type;

	aspv_top_state_type r;
	aspv_top_state_type next_r;

	logic [1:0]  sense;
	logic        short_s;
	logic        present_s;
	logic        tmr_done;
	logic [31:0] tmr_count;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	function automatic logic [4:0] features(input aspv_cfg_type c);
		features = {c.short_recovery_enable, c.power_down_on_short,
			c.open_detect_enable, c.short_detect_enable,
			c.supply_control_enable};
	endfunction

	// ------------------------------------------------------------
	// Sense inputs and timer
	// ------------------------------------------------------------
	aspv_sync #(
		.W (2)
	) u_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  ({i_antenna_short_in_low, i_antenna_present_in}),
		.o_sync   (sense)
	); // R15

	assign short_s   = sense[1];
	assign present_s = sense[0];
	assign tmr_count = r.tmr_long ? 32'(P_RECOVER_CYC) : 32'(SETTLE_CYC); // R15

	aspv_timer u_timer (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_start  (r.tmr_start),
		.i_count  (tmr_count),
		.o_done   (tmr_done)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] clr;
		logic            cut;
		logic            do_wr;
		logic            do_rd;
		ev     = '0;
		clr    = '0;
		cut    = r.cfg.short_recovery_enable | r.cfg.power_down_on_short;
		do_wr  = 1'b0;
		do_rd  = 1'b0;
		next_r = r;
		next_r.msg       = '0;
		next_r.tmr_start = 1'b0;

		// Supervisor sequence
		unique case (r.fsm)
			ST_IDLE: begin
				next_r.ant        = ANT_INIT;
				next_r.supply_off = 1'b0;
				next_r.retest     = 1'b0;
				if (r.cfg.supply_control_enable) begin // R2
					next_r.fsm = ST_FEAT;
				end
			end
			ST_FEAT: begin
				next_r.msg = '{1'b1, MSG_FEATURES, features(r.cfg)}; // R13
				next_r.fsm = ST_INIT;
			end
			ST_INIT: begin
				next_r.msg = '{1'b1, MSG_STATUS, 5'(ANT_INIT)}; // R13
				next_r.fsm = ST_RUN;
			end
			ST_RUN: begin
				if (r.ant == ANT_SHORT) begin
					if (!r.cfg.short_detect_enable) begin // R6
						next_r.ant        = ANT_OK;
						next_r.supply_off = 1'b0;
						next_r.retest     = 1'b0;
						ev[EV_OK]         = 1'b1;
					end else if (tmr_done && !r.retest) begin
						// Power back on, let the line settle
						next_r.supply_off = 1'b0; // R9
						next_r.retest     = 1'b1;
						next_r.tmr_start  = 1'b1;
						next_r.tmr_long   = 1'b0;
						ev[EV_RETEST]     = 1'b1;
					end else if (tmr_done) begin
						next_r.retest = 1'b0;
						if (short_s) begin
							next_r.ant = ANT_OK; // R9
							ev[EV_OK]  = 1'b1;
						end else begin
							next_r.supply_off = 1'b1; // R8
							next_r.tmr_start  = 1'b1;
							next_r.tmr_long   = 1'b1;
						end
					end
				end else if (r.cfg.short_detect_enable && !short_s) begin // R4
					next_r.ant        = ANT_SHORT; // R5
					next_r.supply_off = cut; // R8
					ev[EV_SHORT]      = 1'b1;
					if (r.cfg.short_recovery_enable) begin // R7
						next_r.tmr_start = 1'b1;
						next_r.tmr_long  = 1'b1;
					end
				end else if (r.cfg.open_detect_enable && !present_s) begin // R10
					if (r.ant != ANT_OPEN) begin
						next_r.ant    = ANT_OPEN; // R11
						ev[EV_OPEN]   = 1'b1;
					end
				end else if (r.ant != ANT_OK) begin
					next_r.ant = ANT_OK; // R14
					ev[EV_OK]  = 1'b1;
				end
				if (next_r.ant != r.ant) begin
					next_r.msg = '{1'b1, MSG_STATUS, 5'(next_r.ant)};
				end
			end
			default: begin
				next_r.fsm = ST_IDLE;
			end
		endcase

		// Switching supply control off silences messages and new events
		if (!r.cfg.supply_control_enable) begin // R1
			next_r.fsm = ST_IDLE;
			next_r.msg = '0;
			ev         = '0;
		end

		// Bus: address and data latched in either order
		if (i_axi.awvalid && r.axi.awready) begin
			next_r.aw_held = 1'b1;
			next_r.awaddr  = i_axi.awaddr;
		end
		if (i_axi.wvalid && r.axi.wready) begin
			next_r.w_held = 1'b1;
			next_r.wdata  = i_axi.wdata;
			next_r.wstrb  = i_axi.wstrb;
		end
		if (r.aw_held && r.w_held && !r.axi.bvalid) begin
			do_wr              = 1'b1;
			next_r.aw_held     = 1'b0;
			next_r.w_held      = 1'b0;
			next_r.axi.bvalid  = 1'b1;
			next_r.axi.bresp   = RESP_OKAY;
		end
		if (r.axi.bvalid && i_axi.bready) begin
			next_r.axi.bvalid = 1'b0;
		end
		if (do_wr) begin
			if (hit(r.awaddr, OFF_CONFIG)) begin
				if (r.wstrb[0]) begin
					next_r.cfg = r.wdata[4:0];
				end
			end else if (hit(r.awaddr, OFF_IRQ_CLR)) begin
				if (r.wstrb[0]) begin
					clr = r.wdata[EV_W-1:0];
				end
			end else if (hit(r.awaddr, OFF_IRQ_EN)) begin
				if (r.wstrb[0]) begin
					next_r.irq_en = r.wdata[EV_W-1:0];
				end
			end else if (!hit(r.awaddr, OFF_STATUS)
					&& !hit(r.awaddr, OFF_FEATURE)
					&& !hit(r.awaddr, OFF_IRQ_ST)) begin
				next_r.axi.bresp = RESP_SLVERR;
			end
		end

		do_rd = i_axi.arvalid && r.axi.arready;
		if (do_rd) begin
			next_r.axi.rvalid = 1'b1;
			next_r.axi.rresp  = RESP_OKAY;
			next_r.axi.rdata  = '0;
			if (hit(i_axi.araddr, OFF_CONFIG)) begin
				next_r.axi.rdata[4:0] = r.cfg;
			end else if (hit(i_axi.araddr, OFF_STATUS)) begin
				// Status fields read zero while not reporting
				if (r.fsm != ST_IDLE) begin // R1
					next_r.axi.rdata[1:0] = r.ant;
					next_r.axi.rdata[2]   = !r.supply_off;
					next_r.axi.rdata[3]   = 1'b1;
				end
				next_r.axi.rdata[4] = short_s;
				next_r.axi.rdata[5] = present_s;
			end else if (hit(i_axi.araddr, OFF_FEATURE)) begin
				next_r.axi.rdata[4:0] = features(r.cfg);
			end else if (hit(i_axi.araddr, OFF_IRQ_ST)) begin
				next_r.axi.rdata[EV_W-1:0] = r.irq_st;
			end else if (hit(i_axi.araddr, OFF_IRQ_EN)) begin
				next_r.axi.rdata[EV_W-1:0] = r.irq_en;
			end else if (!hit(i_axi.araddr, OFF_IRQ_CLR)) begin
				next_r.axi.rresp = RESP_SLVERR;
			end
		end else if (r.axi.rvalid && i_axi.rready) begin
			next_r.axi.rvalid = 1'b0;
		end

		// New events win over a clear in the same cycle
		next_r.irq_st      = (r.irq_st & ~clr) | ev;
		next_r.irq         = |(next_r.irq_st & next_r.irq_en);
		next_r.axi.awready = !next_r.aw_held && !next_r.axi.bvalid;
		next_r.axi.wready  = !next_r.w_held && !next_r.axi.bvalid;
		next_r.axi.arready = !next_r.axi.rvalid;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r             <= '0;
			r.fsm         <= ST_IDLE;
			r.cfg         <= CFG_RST;
			r.ant         <= ANT_INIT;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_axi                    = r.axi;
	assign o_antenna_supply_off_out = r.supply_off; // R3
	assign o_msg                    = r.msg;
	assign o_irq                    = r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	quiet_when_off_a: assert property ( // R1
		!r.cfg.supply_control_enable |=> r.fsm == ST_IDLE && !r.msg.valid)
		else $error("report while supply control off");

	start_on_enable_a: assert property ( // R2
		r.fsm == ST_IDLE && r.cfg.supply_control_enable
		|=> r.fsm == ST_FEAT)
		else $error("supply control enable ignored");

	cut_only_short_a: assert property ( // R3
		r.supply_off |-> r.ant == ANT_SHORT)
		else $error("supply off without a short");

	short_seen_a: assert property ( // R4
		r.fsm == ST_RUN && r.cfg.supply_control_enable
		&& r.cfg.short_detect_enable && !short_s && r.ant != ANT_SHORT
		|=> r.ant == ANT_SHORT && r.msg.valid)
		else $error("short not reported");

	power_kept_a: assert property ( // R5
		r.ant != ANT_SHORT && r.cfg.short_detect_enable && !short_s
		&& r.fsm == ST_RUN && !r.cfg.short_recovery_enable
		&& !r.cfg.power_down_on_short && r.cfg.supply_control_enable
		|=> !r.supply_off)
		else $error("power cut without power-down");

	short_held_a: assert property ( // R6
		r.ant == ANT_SHORT && r.cfg.short_detect_enable
		&& r.cfg.supply_control_enable && !r.cfg.short_recovery_enable
		|=> r.ant == ANT_SHORT)
		else $error("short status dropped");

	cut_on_short_a: assert property ( // R8
		r.ant != ANT_SHORT && r.cfg.short_detect_enable && !short_s
		&& r.fsm == ST_RUN && r.cfg.short_recovery_enable
		&& r.cfg.supply_control_enable
		|=> r.supply_off ##1 r.supply_off)
		else $error("power not cut on short");

	retest_power_a: assert property ( // R9
		tmr_done && r.ant == ANT_SHORT && !r.retest && r.fsm == ST_RUN
		&& r.cfg.supply_control_enable && r.cfg.short_detect_enable
		|=> !r.supply_off && r.retest)
		else $error("no re-test after timeout");

	open_seen_a: assert property ( // R11
		r.fsm == ST_RUN && r.cfg.supply_control_enable
		&& r.cfg.open_detect_enable && !present_s && r.ant == ANT_OK
		&& !(r.cfg.short_detect_enable && !short_s)
		|=> r.ant == ANT_OPEN)
		else $error("open not reported");

	start_order_a: assert property ( // R13
		r.msg.valid && r.msg.kind == MSG_FEATURES
		&& r.cfg.supply_control_enable
		|=> r.msg.valid && r.msg.kind == MSG_STATUS
		&& r.msg.code == 5'h00)
		else $error("INIT does not follow feature list");

	sync_lat_a: assert property ( // R15
		$fell(i_antenna_short_in_low) ##1 !i_antenna_short_in_low
		|=> !short_s)
		else $error("short input latency wrong");

	recover_c: cover property (
		r.ant == ANT_SHORT && r.retest ##[1:20] r.ant == ANT_OK);
	open_c: cover property (r.ant == ANT_OPEN);
	announce_c: cover property (
		r.fsm == ST_FEAT ##2 r.fsm == ST_RUN ##1 r.ant == ANT_OK);

endmodule

// ---- tb_aspv_top.sv ----
/*
 * Self-checking bench for the antenna supervisor.
 * Assumes the design answers on AXI4-Lite and emits one-cycle messages.
 */
`timescale 1ns/1ns
module tb_aspv_top
	import aspv_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int REC = 20;
	logic             i_clk    = 1'b0;
	logic             i_resetn = 1'b0;
	aspv_axi_in_type  axi      = '0;
	aspv_axi_out_type axo;
	aspv_msg_type     msg;
	aspv_msg_type     mq[$];
	logic             short_n;
	logic             present;
	logic             supply_off;
	logic             irq;
	logic             fault    = 1'b0;
	logic             conn     = 1'b1;
	logic [31:0]      rd;
	logic [1:0]       rsp;
	int               err_count = 0;
	int               tests_run = 0;

	always #4 i_clk = ~i_clk;

	aspv_top #(.P_RECOVER_CYC(REC)) i_aspv_top (
		.i_clk                   (i_clk),
		.i_resetn                (i_resetn),
		.i_axi                   (axi),
		.o_axi                   (axo),
		.i_antenna_short_in_low  (short_n),
		.i_antenna_present_in    (present),
		.o_antenna_supply_off_out(supply_off),
		.o_msg                   (msg),
		.o_irq                   (irq)
	);

	aspv_antenna_model i_aspv_antenna_model (
		.i_short_fault           (fault),
		.i_connected             (conn),
		.i_antenna_supply_off_out(supply_off),
		.o_antenna_short_in_low  (short_n),
		.o_antenna_present_in    (present)
	);

	// Messages last one cycle; collect them so bus waits miss none
	always @(posedge i_clk) begin
		if (msg.valid === 1'b1)
			mq.push_back(msg);
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input bit ok, input string s);
		tests_run++;
		if (!ok) begin
			err_count++;
			$display("BAD %0t %s", $time, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		axi.awvalid <= 1'b1;
		axi.awaddr  <= a;
		axi.wvalid  <= 1'b1;
		axi.wdata   <= d;
		axi.wstrb   <= 4'hf;
		axi.bready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (axi.awvalid && axo.awready === 1'b1)
				axi.awvalid <= 1'b0;
			if (axi.wvalid && axo.wready === 1'b1)
				axi.wvalid <= 1'b0;
		end while (axo.bvalid !== 1'b1 && n < 100);
		rsp = axo.bresp;
		axi.bready <= 1'b0;
		if (n >= 100)
			chk(1'b0, "write hang");
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge i_clk);
		axi.arvalid <= 1'b1;
		axi.araddr  <= a;
		axi.rready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (axi.arvalid && axo.arready === 1'b1)
				axi.arvalid <= 1'b0;
		end while (axo.rvalid !== 1'b1 && n < 100);
		rd  = axo.rdata;
		rsp = axo.rresp;
		axi.rready <= 1'b0;
		if (n >= 100)
			chk(1'b0, "read hang");
	endtask

	task automatic expect_msg(input logic k, input logic [4:0] c,
		input string s);
		aspv_msg_type m;
		int n;
		n = 0;
		while (mq.size() == 0 && n < 300) begin
			@(posedge i_clk);
			n++;
		end
		#1;
		if (mq.size() == 0) begin
			chk(1'b0, "message missing");
		end else begin
			m = mq.pop_front();
			chk(m.kind === k && m.code === c, s);
		end
	endtask

	// Restart from idle so the start-up sequence is seen again
	task automatic enable(input logic [4:0] cfg, input logic [4:0] feat);
		wr(OFF_CONFIG, 32'h0);
		repeat (8) @(posedge i_clk);
		mq.delete();
		wr(OFF_CONFIG, {27'h0, cfg});
		expect_msg(MSG_FEATURES, feat, "feature list");
		expect_msg(MSG_STATUS, 5'h00, "init status");
		expect_msg(MSG_STATUS, 5'h01, "first status ok");
		chk(supply_off === 1'b0, "antenna not powered");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idle();
		fault <= 1'b1;
		rdr(OFF_CONFIG);
		chk(rd === 32'h0 && rsp === RESP_OKAY, "config reset");
		rdr(OFF_IRQ_EN);
		chk(rd === 32'h0, "irq enable reset");
		wr(OFF_STATUS, 32'h1f);
		chk(rsp === RESP_OKAY, "read-only write resp");
		repeat (30) @(posedge i_clk);
		rdr(OFF_STATUS);
		// Status fields blank; sense lines: short pulled low, present high
		chk(rd[3:0] === 4'h0 && rd[5:4] === 2'h2, "status while idle");
		chk(mq.size() == 0 && supply_off === 1'b0, "idle quiet");
		rdr(8'h20);
		chk(rsp === RESP_SLVERR && rd === 32'h0, "unmapped read");
		wr(8'h24, 32'h1);
		chk(rsp === RESP_SLVERR, "unmapped write");
		fault <= 1'b0;
	endtask

	task automatic t_short_hold();
		enable(5'h03, 5'h03);
		wr(OFF_IRQ_EN, 32'h1);
		fault <= 1'b1;
		expect_msg(MSG_STATUS, 5'h02, "short seen");
		repeat (2) @(posedge i_clk);
		chk(supply_off === 1'b0 && irq === 1'b1, "power kept, irq");
		wr(OFF_IRQ_EN, 32'h0);
		repeat (2) @(posedge i_clk);
		chk(irq === 1'b0, "irq masked");
		wr(OFF_IRQ_CLR, 32'hf);
		rdr(OFF_IRQ_ST);
		chk(rd === 32'h0, "irq cleared");
		fault <= 1'b0;
		repeat (60) @(posedge i_clk);
		rdr(OFF_STATUS);
		chk(rd[1:0] === 2'h2 && mq.size() == 0, "short sticky");
		wr(OFF_CONFIG, 32'h1);
		expect_msg(MSG_STATUS, 5'h01, "detect off clears");
	endtask

	task automatic t_power_down_on_short();
		enable(5'h13, 5'h0b);
		fault <= 1'b1;
		expect_msg(MSG_STATUS, 5'h02, "short with power-down");
		repeat (40) @(posedge i_clk);
		chk(supply_off === 1'b1 && mq.size() == 0, "power held off");
		fault <= 1'b0;
		wr(OFF_CONFIG, 32'h1);
		expect_msg(MSG_STATUS, 5'h01, "detect off restores");
		chk(supply_off === 1'b0, "power restored");
	endtask

	task automatic t_recover();
		enable(5'h07, 5'h13);
		fault <= 1'b1;
		expect_msg(MSG_STATUS, 5'h02, "short with recovery");
		repeat (2) @(posedge i_clk);
		chk(supply_off === 1'b1, "power cut");
		rdr(OFF_STATUS);
		chk(rd[2:0] === 3'h2, "short, power off");
		// Keep the fault over at least one failed re-test
		repeat (2 * REC + 20) @(posedge i_clk);
		chk(mq.size() == 0, "failed retest stays short");
		fault <= 1'b0;
		expect_msg(MSG_STATUS, 5'h01, "recovered ok");
		repeat (2) @(posedge i_clk);
		chk(supply_off === 1'b0, "power back");
		rdr(OFF_STATUS);
		chk(rd[2:0] === 3'h5, "ok, power on");
		rdr(OFF_IRQ_ST);
		chk(rd[3] === 1'b1, "retest event");
	endtask

	task automatic t_open();
		enable(5'h09, 5'h05);
		conn <= 1'b0;
		expect_msg(MSG_STATUS, 5'h03, "open seen");
		rdr(OFF_IRQ_ST);
		chk(rd[1] === 1'b1, "open event");
		conn <= 1'b1;
		expect_msg(MSG_STATUS, 5'h01, "antenna back");
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_idle();
		t_short_hold();
		t_power_down_on_short();
		t_recover();
		t_open();
		complete_run();
	end

	// Whole run needs a few hundred cycles
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
endmodule
